/* File: hdl/awd_pkg.sv */
// package: register map, reset values and timing for the window detector
package awd_pkg;
  localparam logic [7:0] ADDR_UPPER_LOW  = 8'hC4;  // upper compare low byte
  localparam logic [7:0] ADDR_UPPER_HIGH = 8'hC5;  // upper compare high byte
  localparam logic [7:0] ADDR_LOWER_LOW  = 8'hC6;  // lower compare low byte
  localparam logic [7:0] ADDR_LOWER_HIGH = 8'hC7;  // lower compare high byte
  localparam logic [7:0] ADDR_EXT_IE1    = 8'hE6;  // extended interrupt enable one
  localparam logic [7:0] ADDR_CONV_CTRL  = 8'hE8;  // converter control reg
  localparam logic [7:0] RST_UPPER       = 8'hFF;  // upper bytes reset to ones
  localparam logic [7:0] RST_LOWER       = 8'h00;  // lower bytes reset to zeros
  localparam logic [7:0] RST_EXT_IE1     = 8'h00;  // enables off after reset
  localparam logic [7:0] RST_CONV_CTRL   = 8'h00;  // control reset value
  localparam int         WIN_IE_BIT      = 2;      // window irq enable position
  localparam int         WIN_FLAG_BIT    = 1;      // window match flag position
  localparam int         LJUST_BIT       = 0;      // left justify position
  localparam int         CONV_CLOCKS     = 16;     // converter clocks per conversion
  localparam logic [4:0] CONV_CLOCKS_M1  = 5'h0F;  // last count of a conversion
  localparam int         RESULT_W        = 10;     // converter resolution
endpackage : awd_pkg

/* File: hdl/awd_compare.sv */
// window comparison of one result against the two limit words
module awd_compare
  import awd_pkg::*;
(
  input  wire logic [15:0] result_word,  // justified conversion result
  input  wire logic [15:0] upper_word,   // greater-than limit
  input  wire logic [15:0] lower_word,   // less-than limit
  output wire logic        hit           // window condition met
);
  // inside mode when lower limit exceeds upper limit
  wire logic inside_mode = lower_word > upper_word;
  wire logic above       = result_word > upper_word;
  wire logic below       = result_word < lower_word;
  // inside: strictly between; outside: below or above
  assign hit = inside_mode ? (above && below) : (above || below);
endmodule : awd_compare

/* File: hdl/awd_window_detector.sv */
// window detector: limit registers, conversion timer, flag and request
//
// Functional notes
// - compare every new result, notify on match
// - match flag lives in converter control
// - upper limit from two bytes, reset ones
// - lower limit from two bytes, reset zeros
// - limit order selects inside or outside
// - request forwarded only while enable bit set
// - sixteen converter clocks per conversion result
// - hardware only sets flag; software writes zero
module awd_window_detector
  import awd_pkg::*;
(
  input  wire logic                core_clk,    // system clock, 100 MHz
  input  wire logic                srst,        // synchronous reset, active high
  input  wire logic [7:0]          reg_addr,    // register address
  input  wire logic                reg_wr,      // write strobe, one cycle
  input  wire logic [7:0]          reg_wdata,   // write data
  input  wire logic                reg_rd,      // read strobe, one cycle
  output logic      [7:0]          reg_rdata,   // read data, one cycle later
  input  wire logic                conv_start,  // start one conversion, pulse
  input  wire logic                sar_tick,    // converter clock enable pulse
  input  wire logic [RESULT_W-1:0] adc_value,   // raw converter sample
  output logic      [15:0]         result_out,  // last justified result
  output logic                     conv_busy,   // conversion running
  output logic                     conv_done,   // result presented, pulse
  output logic                     window_irq   // masked window request
);
  // registers
  logic [7:0]  upper_lo_r, upper_hi_r;  // greater-than bytes
  logic [7:0]  lower_lo_r, lower_hi_r;  // less-than bytes
  logic [7:0]  ext_ie1_r;               // extended interrupt enable one
  logic [7:0]  ctrl_r;                  // converter control reg
  logic [4:0]  sar_cnt_r;               // converter clocks elapsed
  logic        compare_r;               // compare pending one cycle
  logic        hit;                     // window condition now

  // decode of write strobes
  wire logic wr_ul = reg_wr && reg_addr == ADDR_UPPER_LOW;
  wire logic wr_uh = reg_wr && reg_addr == ADDR_UPPER_HIGH;
  wire logic wr_ll = reg_wr && reg_addr == ADDR_LOWER_LOW;
  wire logic wr_lh = reg_wr && reg_addr == ADDR_LOWER_HIGH;
  wire logic wr_ie = reg_wr && reg_addr == ADDR_EXT_IE1;
  wire logic wr_cc = reg_wr && reg_addr == ADDR_CONV_CTRL;

  // limit words are plain concatenations
  wire logic [15:0] upper_word = {upper_hi_r, upper_lo_r};
  wire logic [15:0] lower_word = {lower_hi_r, lower_lo_r};

  // justify like the result register pair
  wire logic [15:0] just_value = ctrl_r[LJUST_BIT] ? {adc_value, 6'h00}
                                                    : {6'h00, adc_value};

  // conversion ends on the last converter clock
  wire logic conv_end = conv_busy && sar_tick && sar_cnt_r == CONV_CLOCKS_M1;

  awd_compare u_cmp
  (
    .result_word (result_out),
    .upper_word  (upper_word),
    .lower_word  (lower_word),
    .hit         (hit)
  );

  // match sets, software zero clears; set wins over clear
  wire logic match_set = compare_r && hit;
  wire logic flag_nxt  = match_set ? 1'b1
                       : (wr_cc ? reg_wdata[WIN_FLAG_BIT] & ctrl_r[WIN_FLAG_BIT]
                                : ctrl_r[WIN_FLAG_BIT]);

  // read mux, unmapped reads zero
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (reg_addr)
      ADDR_UPPER_LOW:  rd_mux = upper_lo_r;
      ADDR_UPPER_HIGH: rd_mux = upper_hi_r;
      ADDR_LOWER_LOW:  rd_mux = lower_lo_r;
      ADDR_LOWER_HIGH: rd_mux = lower_hi_r;
      ADDR_EXT_IE1:    rd_mux = ext_ie1_r;
      ADDR_CONV_CTRL:  rd_mux = ctrl_r;
      default:         rd_mux = 8'h00;
    endcase
  end

  // limit byte registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      upper_lo_r <= RST_UPPER;
      upper_hi_r <= RST_UPPER;
      lower_lo_r <= RST_LOWER;
      lower_hi_r <= RST_LOWER;
    end
    else
    begin
      if (wr_ul) upper_lo_r <= reg_wdata;
      if (wr_uh) upper_hi_r <= reg_wdata;
      if (wr_ll) lower_lo_r <= reg_wdata;
      if (wr_lh) lower_hi_r <= reg_wdata;
    end
  end

  // enable and control registers; flag is hardware-set only
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ext_ie1_r <= RST_EXT_IE1;
      ctrl_r    <= RST_CONV_CTRL;
    end
    else
    begin
      if (wr_ie) ext_ie1_r <= reg_wdata;
      if (wr_cc) ctrl_r <= reg_wdata;
      ctrl_r[WIN_FLAG_BIT] <= flag_nxt;
    end
  end

  // conversion timer counts converter clock enables
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      conv_busy <= 1'b0;
      sar_cnt_r <= 5'h00;
    end
    else if (conv_end)
    begin
      conv_busy <= 1'b0;
      sar_cnt_r <= 5'h00;
    end
    else if (conv_busy && sar_tick)
      sar_cnt_r <= sar_cnt_r + 5'h01;
    else if (!conv_busy && conv_start)
      conv_busy <= 1'b1;  // start while busy is ignored
  end

  // result capture and one compare per conversion
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      result_out <= 16'h0000;
      conv_done  <= 1'b0;
      compare_r  <= 1'b0;
    end
    else
    begin
      conv_done <= conv_end;
      compare_r <= conv_end;
      if (conv_end) result_out <= just_value;
    end
  end

  // outputs: masked request and read data
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      window_irq <= 1'b0;
      reg_rdata  <= 8'h00;
    end
    else
    begin
      window_irq <= flag_nxt && ext_ie1_r[WIN_IE_BIT];
      reg_rdata  <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // check-only count of converter clocks seen in the current conversion;
  // kept apart from sar_cnt_r so a wrong end point there is caught
  logic [4:0] ticks_seen_r;  // ticks since the last accepted start
  always_ff @(posedge core_clk)
  begin
    if (srst || (!conv_busy && conv_start))
      ticks_seen_r <= 5'h00;
    else if (conv_busy && sar_tick)
      ticks_seen_r <= ticks_seen_r + 5'h01;
  end

  // assertions
  property p_flag_set;
    @(posedge core_clk) disable iff (srst)
      compare_r && hit |=> ctrl_r[WIN_FLAG_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("match did not set flag");

  property p_flag_hold;
    @(posedge core_clk) disable iff (srst)
      ctrl_r[WIN_FLAG_BIT] && !wr_cc |=> ctrl_r[WIN_FLAG_BIT];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  property p_flag_rise;
    @(posedge core_clk) disable iff (srst)
      $rose(ctrl_r[WIN_FLAG_BIT]) |-> $past(compare_r) && $past(hit);
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag set without match");

  property p_irq_mask;
    @(posedge core_clk) disable iff (srst)
      !ext_ie1_r[WIN_IE_BIT] && !wr_ie |=> !window_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request seen");

  property p_irq_fwd;
    @(posedge core_clk) disable iff (srst)
      ctrl_r[WIN_FLAG_BIT] && ext_ie1_r[WIN_IE_BIT] && !wr_cc && !wr_ie |=> window_irq;
  endproperty
  a_irq_fwd: assert property (p_irq_fwd) else $error("enabled request missing");

  property p_upper_reset;
    @(posedge core_clk) srst |=> upper_word == 16'hFFFF;
  endproperty
  a_upper_reset: assert property (p_upper_reset) else $error("upper limit reset wrong");

  property p_lower_reset;
    @(posedge core_clk) srst |=> lower_word == 16'h0000;
  endproperty
  a_lower_reset: assert property (p_lower_reset) else $error("lower limit reset wrong");

  sequence s_started;
    !conv_busy && conv_start && !srst;
  endsequence
  property p_conv_start;
    @(posedge core_clk) disable iff (srst)
      s_started |=> conv_busy;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("start not taken");

  // done only after exactly the full count of converter clocks
  property p_conv_len;
    @(posedge core_clk) disable iff (srst)
      conv_done |-> ticks_seen_r == 5'(CONV_CLOCKS) && !conv_busy;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_one_compare;
    @(posedge core_clk) disable iff (srst)
      conv_done |-> compare_r ##1 !compare_r;
  endproperty
  a_one_compare: assert property (p_one_compare) else $error("compare not once");

  property p_mode;
    @(posedge core_clk) disable iff (srst)
      lower_word > upper_word && hit |-> result_out < lower_word && result_out > upper_word;
  endproperty
  a_mode: assert property (p_mode) else $error("inside mode mismatch");
endmodule : awd_window_detector

/* File: test/awd_window_detector_tb.sv */
// testbench: random and corner checks of the window detector
module awd_window_detector_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import awd_pkg::*;
  logic        core_clk;     // system clock
  logic        srst;         // sync reset
  logic [7:0]  reg_addr;     // register address
  logic        reg_wr;       // write strobe
  logic [7:0]  reg_wdata;    // write data
  logic        reg_rd;       // read strobe
  logic [7:0]  reg_rdata;    // read data
  logic        conv_start;   // conversion start
  logic        sar_tick;     // converter clock enable
  logic [9:0]  adc_value;    // raw sample
  logic [15:0] result_out;   // justified result
  logic        conv_busy;    // busy level
  logic        conv_done;    // done pulse
  logic        window_irq;   // masked request
  integer      seed;         // random seed
  integer      bad_count;    // mismatches
  integer      n_tests;      // comparisons
  logic [7:0]  v;            // read value
  logic [15:0] up;           // upper limit model
  logic [15:0] lo;           // lower limit model
  logic [15:0] rj;           // justified result model
  logic [9:0]  a;            // sample
  logic [7:0]  en;           // enable reg model
  logic [7:0]  cd;           // control write data
  logic        flag_m;       // sticky flag model
  awd_window_detector u_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .sar_tick(sar_tick), .adc_value(adc_value),
    .result_out(result_out), .conv_busy(conv_busy), .conv_done(conv_done),
    .window_irq(window_irq));
  // free running clock
  always #5 core_clk = ~core_clk;
  // compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // bus write, one strobe cycle
  task wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk) #1 reg_wr = 1'b1;
    reg_addr = ad;
    reg_wdata = d;
    @(posedge core_clk) #1 reg_wr = 1'b0;
  endtask : wr
  // bus read, data one cycle later
  task rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge core_clk) #1 reg_rd = 1'b1;
    reg_addr = ad;
    @(posedge core_clk) #1 reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  // strict bounds; limit order picks inside or outside
  function automatic logic exp_hit(input logic [15:0] r, input logic [15:0] u,
                                   input logic [15:0] l);
    if (l > u) return (r > u) && (r < l);
    return (r < l) || (r > u);
  endfunction : exp_hit
  // one conversion; a stray start mid-run must be ignored
  task conv(input logic [9:0] s, input logic [15:0] e);
    @(posedge core_clk) #1 conv_start = 1'b1;
    adc_value = s;
    @(posedge core_clk) #1;
    chk(conv_busy, 1'b1);
    for (int k = 1; k <= 16; k++)
    begin
      sar_tick = 1'b1;
      conv_start = (k == 8);
      @(posedge core_clk) #1 sar_tick = 1'b0;
      conv_start = 1'b0;
      if (k < 16)
      begin
        chk(conv_done, 1'b0);
        @(posedge core_clk) #1;
      end
    end
    chk(conv_done, 1'b1);
    chk(result_out, e);
    chk(conv_busy, 1'b0);
  endtask : conv
  // verdict and end of run
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // hang guard
  initial
  begin
    #500000 bad_count++;
    finish_test;
  end
  // main sequence
  initial
  begin
    core_clk = 0; srst = 1; reg_addr = 0; reg_wr = 0; reg_wdata = 0; reg_rd = 0;
    conv_start = 0; sar_tick = 0; adc_value = 0; seed = 89284; bad_count = 0;
    n_tests = 0; flag_m = 0;
    repeat (2) @(posedge core_clk);
    #1 srst = 0;
    rd(ADDR_UPPER_LOW, v);  chk(v, RST_UPPER);
    rd(ADDR_UPPER_HIGH, v); chk(v, RST_UPPER);
    rd(ADDR_LOWER_LOW, v);  chk(v, RST_LOWER);
    rd(ADDR_LOWER_HIGH, v); chk(v, RST_LOWER);
    rd(ADDR_EXT_IE1, v);    chk(v, RST_EXT_IE1);
    rd(ADDR_CONV_CTRL, v);  chk(v, RST_CONV_CTRL);
    wr(8'h01, 8'hFF);
    rd(8'h01, v);           chk(v, 8'h00);
    $display("reset and map test done");
    // random limits, often within two counts of the result for boundaries
    for (int i = 0; i < 60; i++)
    begin
      a = $random(seed);
      cd = $random(seed);
      rj = cd[0] ? {a, 6'h00} : {6'h00, a};
      up = (i % 4 == 0) ? $random(seed) : rj + 16'($random(seed) % 2);
      lo = (i % 4 == 0) ? $random(seed) : rj + 16'($random(seed) % 3);
      en = $random(seed);
      wr(ADDR_UPPER_HIGH, up[15:8]);
      wr(ADDR_UPPER_LOW, up[7:0]);
      wr(ADDR_LOWER_HIGH, lo[15:8]);
      wr(ADDR_LOWER_LOW, lo[7:0]);
      wr(ADDR_EXT_IE1, en);
      wr(ADDR_CONV_CTRL, cd);
      flag_m = flag_m & cd[1];
      rd(ADDR_UPPER_LOW, v);  chk(v, up[7:0]);
      rd(ADDR_LOWER_HIGH, v); chk(v, lo[15:8]);
      conv(a, rj);
      flag_m = flag_m | exp_hit(rj, up, lo);
      @(posedge core_clk) #1;
      chk(window_irq, flag_m & en[2]);
      rd(ADDR_CONV_CTRL, v);  chk(v, {cd[7:2], flag_m, cd[0]});
      $display("random test %0d done", i);
    end
    finish_test;
  end
endmodule : awd_window_detector_tb
